// >>> inc/gpt_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: Byte-wide registers reached through a six-bit register address
// Notes: Definitions only, no logic
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH

// Register offsets
// Six bits: the timer data offsets reach past 1f
`define GPT_ADDR_W 6
`define GPT_OFS_PORT_DATA 6'h01
`define GPT_OFS_EDGE_SELECT 6'h03
`define GPT_OFS_LINE_DIRECTION 6'h05
`define GPT_OFS_IRQ_ENABLE_A 6'h07
`define GPT_OFS_IRQ_ENABLE_B 6'h09
`define GPT_OFS_TMR_CTRL_A 6'h19
`define GPT_OFS_TMR_CTRL_B 6'h1b
`define GPT_OFS_TMR_CTRL_CD 6'h1d
`define GPT_OFS_TMR_DATA_A 6'h1f
`define GPT_OFS_TMR_DATA_B 6'h21
`define GPT_OFS_TMR_DATA_C 6'h23
`define GPT_OFS_TMR_DATA_D 6'h25

// Reset value of every register
`define GPT_RST_BYTE 8'h00

// Field positions
`define GPT_CTRL_OUT_RST 4
`define GPT_CD_C_LSB 4
`define GPT_CD_D_LSB 0
`define GPT_EDGE_AUX_A 4
`define GPT_EDGE_AUX_B 3
`define GPT_IEA_LINE_LSB 6
`define GPT_IEA_TMR_A 5
`define GPT_IEA_TMR_B 0
`define GPT_IEB_LINE_HI 6
`define GPT_IEB_TMR_C 5
`define GPT_IEB_TMR_D 4

// Mode field codes and prescaler divisors
`define GPT_MODE_STOP 4'h0
`define GPT_MODE_EVENT 4'h8
`define GPT_DIV_1 8'h04
`define GPT_DIV_2 8'h0a
`define GPT_DIV_3 8'h10
`define GPT_DIV_4 8'h32
`define GPT_DIV_5 8'h40
`define GPT_DIV_6 8'h64
`define GPT_DIV_7 8'hc8

// Counter reload point
`define GPT_CNT_ONE 8'h01
`endif

// >>> inc/gpt_pkg.sv
// Purpose: Types shared by the port and timer block
// Assumes: Offsets and counts live in gpt_map.svh
// Notes: Bus request struct and timer mode enum
package gpt_pkg;
  // One register access request from the host
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] data;
  } gpt_bus_s;

  // Decoded timer operating mode
  typedef enum logic [1:0] {TM_STOP, TM_DELAY, TM_EVENT, TM_PULSE} gpt_tmode_e;
endpackage

// >>> src/gpt_port_timers.sv
// Purpose: Eight-line interrupt I/O port plus four prescaled down-counter timers
// Assumes: Host bus synchronous to clk; pins, aux and timer_osc_in may be asynchronous; timer_osc_in rising edges are timer clocks
// Notes: Channel events are one-cycle pulses for an outside interrupt controller
//
// Summary of operation
// R1 - Output lines drive data bits; inputs float
// R2 - Read returns data for outputs, pins for inputs
// R3 - Edge bit zero falling, one rising
// R4 - Detector is XNOR of edge bit and input
// R5 - Software sets edges before enabling interrupts
// R6 - Direction zero input, one push-pull output
// R7 - Each line's interrupt enabled individually
// R8 - Four 8-bit prescaler and down-counter timers
// R9 - Timer output toggles on each time-out
// R10 - A, B all modes; C, D delay only
// R11 - Delay mode prescaler always runs, decrements counter
// R12 - Passing 01 reloads and emits time-out
// R13 - Prescale change: first time-out within 200 clocks
// R14 - Reload 01 every pulse, 00 every 256
// R15 - Pulse width: lines 4,3 channels use aux
// R16 - Pulse width: count only while aux active
// R17 - Aux active level follows edge bits 4,3
// R18 - Pulse width interrupt on opposite transition
// R19 - Software rewrites data register after each measure
// R20 - Running write takes effect after passing 01
// R21 - Software avoids writes as aux activates
// R22 - Leaving pulse mode restores normal edges
// R23 - Mode field decode: stop, delay, event, pulse
// R24 - Stopped write loads counter; running waits
// R25 - Pins and aux synchronised before use
`default_nettype none
`include "gpt_map.svh"

module gpt_port_timers
  import gpt_pkg::*;
#(
  parameter int LINES = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire gpt_bus_s host_bus,
  output logic [7:0] rd_data,
  input wire logic [7:0] port_line_in,
  output logic [7:0] port_line_out,
  output logic [7:0] port_line_oe,
  input wire logic aux_input_a,
  input wire logic aux_input_b,
  input wire logic timer_osc_in,
  output logic [3:0] timer_out,
  output logic [7:0] line_event,
  output logic [3:0] timer_event
);

  // The port logic is written for exactly one byte of lines
  if (LINES != 8) begin : g_bad_lines
    $error("gpt_port_timers supports LINES = 8 only");
  end

  // Software registers
  logic [7:0] port_data_ff; // Output data bits
  logic [7:0] edge_select_ff; // Active edges
  logic [7:0] line_direction_ff; // One means output
  logic [7:0] irq_enable_a_ff;
  logic [7:0] irq_enable_b_ff;
  logic [3:0] mode_field_a_ff;
  logic [3:0] mode_field_b_ff;
  logic [7:0] ctrl_cd_ff; // Two three-bit delay fields
  logic [7:0] rd_data_ff;
  logic [7:0] line_event_ff;

  // Synchronisers: first stage read only by second
  logic [10:0] sync1_ff;
  logic [10:0] sync2_ff;
  logic osc_prev_ff; // Edge detect on the settled oscillator
  logic [7:0] det_prev_ff; // Previous detector output per line

  // Settled levels
  wire [7:0] pin_s = sync2_ff[7:0];
  wire [1:0] aux_s = sync2_ff[9:8];
  wire osc_s = sync2_ff[10];
  wire tmr_tick = osc_s & ~osc_prev_ff; // R8

  // Address decode
  wire wr = host_bus.wr;
  wire [5:0] adr = host_bus.addr;
  wire [7:0] wd = host_bus.data;
  wire wr_pd = wr && (adr == `GPT_OFS_PORT_DATA);
  wire wr_es = wr && (adr == `GPT_OFS_EDGE_SELECT);
  wire wr_dir = wr && (adr == `GPT_OFS_LINE_DIRECTION);
  wire wr_iea = wr && (adr == `GPT_OFS_IRQ_ENABLE_A);
  wire wr_ieb = wr && (adr == `GPT_OFS_IRQ_ENABLE_B);
  wire wr_ca = wr && (adr == `GPT_OFS_TMR_CTRL_A);
  wire wr_cb = wr && (adr == `GPT_OFS_TMR_CTRL_B);
  wire wr_ccd = wr && (adr == `GPT_OFS_TMR_CTRL_CD);

  // Per-timer views, filled by the assigns below and the generate loop
  wire [7:0] cnt_w [4];
  wire [3:0] cpulse_w;
  wire [3:0] tout_w;
  wire [3:0] out_w;
  wire [3:0] mf_w [4];
  gpt_tmode_e tmode_w [4];
  wire [5:0] dat_ofs [4];
  wire [3:0] ie_tmr;

  assign mf_w[0] = mode_field_a_ff;
  assign mf_w[1] = mode_field_b_ff;
  assign mf_w[2] = {1'b0, ctrl_cd_ff[`GPT_CD_C_LSB +: 3]}; // R10
  assign mf_w[3] = {1'b0, ctrl_cd_ff[`GPT_CD_D_LSB +: 3]}; // R10
  assign dat_ofs[0] = `GPT_OFS_TMR_DATA_A;
  assign dat_ofs[1] = `GPT_OFS_TMR_DATA_B;
  assign dat_ofs[2] = `GPT_OFS_TMR_DATA_C;
  assign dat_ofs[3] = `GPT_OFS_TMR_DATA_D;
  assign ie_tmr = {irq_enable_b_ff[`GPT_IEB_TMR_D], irq_enable_b_ff[`GPT_IEB_TMR_C],
                   irq_enable_a_ff[`GPT_IEA_TMR_B], irq_enable_a_ff[`GPT_IEA_TMR_A]}; // R7

  // Aux active level per A/B timer
  wire [1:0] aux_edge = {edge_select_ff[`GPT_EDGE_AUX_B], edge_select_ff[`GPT_EDGE_AUX_A]};
  wire [1:0] aux_act = ~(aux_s ^ aux_edge); // R17

  // Prescaler divisor per selection
  function automatic logic [7:0] gpt_div(input logic [2:0] sel);
    logic [7:0] d;
    d = `GPT_DIV_1;
    case (sel)
      3'h2: d = `GPT_DIV_2;
      3'h3: d = `GPT_DIV_3;
      3'h4: d = `GPT_DIV_4;
      3'h5: d = `GPT_DIV_5;
      3'h6: d = `GPT_DIV_6;
      3'h7: d = `GPT_DIV_7;
      default: d = `GPT_DIV_1;
    endcase
    return d;
  endfunction

  // A stopped timer clears its prescaler; a gated one holds it
  function automatic logic [7:0] pre_pre_hold(input logic [7:0] p, input logic stop);
    return stop ? `GPT_RST_BYTE : p;
  endfunction

  // One timer per iteration
  for (genvar t = 0; t < 4; t++) begin : g_tmr
    logic [7:0] pre_ff; // Prescaler count
    logic [7:0] cnt_ff; // Main down-counter
    logic [7:0] dat_ff; // Reload value
    logic out_ff;
    logic act_prev_ff; // Event count edge memory
    gpt_tmode_e tmode;
    wire is_ab = (t < 2);
    wire act = is_ab ? aux_act[t % 2] : 1'b0;
    wire [7:0] div = gpt_div(mf_w[t][2:0]);

    // Mode field decode
    assign tmode = (mf_w[t] == `GPT_MODE_STOP) ? TM_STOP :
                   (!mf_w[t][3]) ? TM_DELAY :
                   (mf_w[t] == `GPT_MODE_EVENT) ? TM_EVENT : TM_PULSE; // R23
    // Delay always runs; pulse width only while aux active
    wire run = (tmode == TM_DELAY) || (tmode == TM_PULSE && act); // R11 R16
    wire pre_wrap = (pre_ff >= div - `GPT_CNT_ONE);
    // Prescaled pulse, or bare active aux edge in event mode
    wire cpulse = (run && tmr_tick && pre_wrap) ||
                  (tmode == TM_EVENT && act && !act_prev_ff);
    wire tout = cpulse && (cnt_ff == `GPT_CNT_ONE); // R12
    wire wr_dat = wr && (adr == dat_ofs[t]);
    wire wr_ctl = is_ab && (t == 0 ? wr_ca : wr_cb);
    wire out_clr = wr_ctl && wd[`GPT_CTRL_OUT_RST]; // Forced low during the write

    // Prescaler keeps its phase on a divisor change, so the first
    // time-out may land early but never later than one full wrap
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        pre_ff <= `GPT_RST_BYTE;
        act_prev_ff <= 1'b0;
      end else if (ce) begin
        act_prev_ff <= act;
        if (!run) begin
          pre_ff <= pre_pre_hold(pre_ff, tmode == TM_STOP);
        end else if (tmr_tick) begin
          pre_ff <= pre_wrap ? `GPT_RST_BYTE : pre_ff + `GPT_CNT_ONE; // R13
        end
      end
    end

    // Main counter, reload and output toggle
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cnt_ff <= `GPT_RST_BYTE;
        dat_ff <= `GPT_RST_BYTE;
        out_ff <= 1'b0;
      end else if (ce) begin
        if (wr_dat) begin
          dat_ff <= wd;
        end
        if (wr_dat && tmode == TM_STOP) begin
          cnt_ff <= wd; // R24
        end else if (tout) begin
          cnt_ff <= dat_ff; // R12 R14 R20
        end else if (cpulse) begin
          cnt_ff <= cnt_ff - `GPT_CNT_ONE; // R11 R14
        end
        if (out_clr) begin
          out_ff <= 1'b0;
        end else if (tout) begin
          out_ff <= ~out_ff; // R9
        end
      end
    end

    assign cnt_w[t] = cnt_ff;
    assign cpulse_w[t] = cpulse;
    assign tout_w[t] = tout;
    assign out_w[t] = out_ff;
    assign tmode_w[t] = tmode;
  end

  // Lines 4 and 3 take aux inputs while their timer uses them
  wire a_aux = (tmode_w[0] == TM_PULSE) || (tmode_w[0] == TM_EVENT); // R15
  wire b_aux = (tmode_w[1] == TM_PULSE) || (tmode_w[1] == TM_EVENT); // R15
  wire [7:0] src = {pin_s[7:5], a_aux ? aux_s[0] : pin_s[4],
                    b_aux ? aux_s[1] : pin_s[3], pin_s[2:0]};
  // Pulse width mode flips the edge so the pulse end interrupts
  wire [7:0] flip = {3'h0, tmode_w[0] == TM_PULSE, tmode_w[1] == TM_PULSE, 3'h0}; // R18 R22
  // Detector output rises on the chosen transition
  wire [7:0] det = ~(edge_select_ff ^ flip ^ src); // R3 R4
  wire [7:0] ie_line = {irq_enable_a_ff[`GPT_IEA_LINE_LSB +: 2],
                        irq_enable_b_ff[`GPT_IEB_LINE_HI +: 2], irq_enable_b_ff[3:0]};

  // Read data: outputs from register, inputs from pins
  wire [7:0] port_rd = (port_data_ff & line_direction_ff) | (pin_s & ~line_direction_ff); // R2
  wire [7:0] rd_mux =
    (adr == `GPT_OFS_PORT_DATA) ? port_rd :
    (adr == `GPT_OFS_EDGE_SELECT) ? edge_select_ff :
    (adr == `GPT_OFS_LINE_DIRECTION) ? line_direction_ff :
    (adr == `GPT_OFS_IRQ_ENABLE_A) ? irq_enable_a_ff :
    (adr == `GPT_OFS_IRQ_ENABLE_B) ? irq_enable_b_ff :
    (adr == `GPT_OFS_TMR_CTRL_A) ? {4'h0, mode_field_a_ff} :
    (adr == `GPT_OFS_TMR_CTRL_B) ? {4'h0, mode_field_b_ff} :
    (adr == `GPT_OFS_TMR_CTRL_CD) ? ctrl_cd_ff :
    (adr == `GPT_OFS_TMR_DATA_A) ? cnt_w[0] :
    (adr == `GPT_OFS_TMR_DATA_B) ? cnt_w[1] :
    (adr == `GPT_OFS_TMR_DATA_C) ? cnt_w[2] :
    (adr == `GPT_OFS_TMR_DATA_D) ? cnt_w[3] : `GPT_RST_BYTE;

  // Synchronisers and edge memories
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 11'h000;
      sync2_ff <= 11'h000;
      osc_prev_ff <= 1'b0;
      det_prev_ff <= `GPT_RST_BYTE;
    end else if (ce) begin
      sync1_ff <= {timer_osc_in, aux_input_b, aux_input_a, port_line_in}; // R25
      sync2_ff <= sync1_ff; // R25
      osc_prev_ff <= osc_s;
      det_prev_ff <= det;
    end
  end

  // Register writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_data_ff <= `GPT_RST_BYTE;
      edge_select_ff <= `GPT_RST_BYTE;
      line_direction_ff <= `GPT_RST_BYTE;
      irq_enable_a_ff <= `GPT_RST_BYTE;
      irq_enable_b_ff <= `GPT_RST_BYTE;
      mode_field_a_ff <= 4'h0;
      mode_field_b_ff <= 4'h0;
      ctrl_cd_ff <= `GPT_RST_BYTE;
    end else if (ce) begin
      if (wr_pd) port_data_ff <= wd; // R1
      if (wr_es) edge_select_ff <= wd;
      if (wr_dir) line_direction_ff <= wd; // R6
      if (wr_iea) irq_enable_a_ff <= wd;
      if (wr_ieb) irq_enable_b_ff <= wd;
      if (wr_ca) mode_field_a_ff <= wd[3:0];
      if (wr_cb) mode_field_b_ff <= wd[3:0];
      if (wr_ccd) ctrl_cd_ff <= {1'b0, wd[6:4], 1'b0, wd[2:0]};
    end
  end

  // Read data and channel events, all registered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_ff <= `GPT_RST_BYTE;
      line_event_ff <= `GPT_RST_BYTE;
    end else if (ce) begin
      if (host_bus.rd) rd_data_ff <= rd_mux;
      line_event_ff <= det & ~det_prev_ff & ie_line; // R7
    end
  end

  logic [3:0] timer_event_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_event_ff <= 4'h0;
    end else if (ce) begin
      timer_event_ff <= tout_w & ie_tmr; // R7 R12
    end
  end

  assign rd_data = rd_data_ff;
  assign port_line_out = port_data_ff; // R1
  assign port_line_oe = line_direction_ff; // R6
  assign timer_out = out_w;
  assign line_event = line_event_ff;
  assign timer_event = timer_event_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_port_write;
    ce && wr_pd |=> port_line_out == $past(wd);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port data not driven"); // R1
  property p_dir_write;
    ce && wr_dir |=> port_line_oe == $past(wd);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not applied"); // R6
  property p_port_read;
    ce && host_bus.rd && adr == `GPT_OFS_PORT_DATA |=> rd_data == $past(port_rd);
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read mixes wrong"); // R2
  property p_line0_event;
    ce && irq_enable_b_ff[0] && det[0] && !det_prev_ff[0] |=> line_event[0];
  endproperty
  a_line0_event: assert property (p_line0_event) else $error("line 0 event lost"); // R4
  property p_toggle;
    ce && tout_w[2] |=> timer_out[2] != $past(timer_out[2]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("timer C did not toggle"); // R9
  property p_reload;
    ce && tout_w[3] && !(wr && adr == `GPT_OFS_TMR_DATA_D) |=> cnt_w[3] == g_tmr[3].dat_ff;
  endproperty
  a_reload: assert property (p_reload) else $error("timer D reload wrong"); // R12
  property p_decrement;
    ce && cpulse_w[2] && cnt_w[2] != `GPT_CNT_ONE && !(wr && adr == `GPT_OFS_TMR_DATA_C)
      |=> cnt_w[2] == $past(cnt_w[2]) - `GPT_CNT_ONE;
  endproperty
  a_decrement: assert property (p_decrement) else $error("count pulse missed"); // R11
  property p_gate;
    ce && tmode_w[0] == TM_PULSE && !aux_act[0] && !(wr && adr == `GPT_OFS_TMR_DATA_A)
      |=> $stable(cnt_w[0]);
  endproperty
  a_gate: assert property (p_gate) else $error("timer A ran while gated"); // R16
  property p_stopped_load;
    ce && tmode_w[1] == TM_STOP && wr && adr == `GPT_OFS_TMR_DATA_B |=> cnt_w[1] == $past(wd);
  endproperty
  a_stopped_load: assert property (p_stopped_load) else $error("stopped load failed"); // R24

  c_timeout_a: cover property (tout_w[0] && tmode_w[0] == TM_DELAY);
  c_pulse_end: cover property (line_event[4] && tmode_w[0] == TM_PULSE);
  c_event_count: cover property (cpulse_w[1] && tmode_w[1] == TM_EVENT);
  c_every_pulse: cover property (tout_w[2] ##[1:300] tout_w[2]);

endmodule
`default_nettype wire

// >>> bench/gpt_host_model.sv
// Purpose: Host processor model issuing byte register accesses
// Assumes: Requests launch at the falling edge and are taken at the next rise
// Notes: Released address and data show inverted values, never the last ones
`default_nettype none
module gpt_host_model
  import gpt_pkg::*;
(
  input wire logic clk,
  output var gpt_bus_s bus,
  input wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus from time zero
  initial begin
    bus = '0;
  end

  // Write held across the taking edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(negedge clk);
    bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask

  // Read data lands one edge after the take
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    bus = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(negedge clk);
    d = rd_data;
    bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hff};
  endtask
endmodule
`default_nettype wire

// >>> bench/gpt_port_and_timers_test.sv
// Purpose: Self-checking bench for the port and timer block
// Assumes: Timer clock runs at a quarter of clk, far below the clk/2 limit
// Notes: Event counts are kept by a monitor and compared after each step
`default_nettype none
`include "gpt_map.svh"
module gpt_port_and_timers_test
  import gpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  gpt_bus_s host_bus;
  logic [7:0] rd_data, p_out, p_oe, lev;
  logic [7:0] pin = 8'h00;
  logic aux_a = 1'b0;
  logic aux_b = 1'b0;
  logic osc = 1'b0;
  logic [3:0] t_out, t_ev;
  int err_count = 0;
  int n_compared = 0;
  int ev_t[4];
  int ev_l[8];
  int m[64];
  int divs[7] = '{4, 10, 16, 50, 64, 100, 200};
  logic [7:0] seq[6] = '{8'h01, 8'h81, 8'h80, 8'h00, 8'h02, 8'h00};

  // 20 MHz clock
  always #25 clk = ~clk;

  gpt_host_model host_u (.clk(clk), .bus(host_bus), .rd_data(rd_data));

  gpt_port_timers #(.LINES(8)) dut_u (
    .clk(clk), .reset_n(reset_n), .ce(ce), .host_bus(host_bus),
    .rd_data(rd_data), .port_line_in(pin), .port_line_out(p_out),
    .port_line_oe(p_oe), .aux_input_a(aux_a), .aux_input_b(aux_b),
    .timer_osc_in(osc), .timer_out(t_out), .line_event(lev),
    .timer_event(t_ev)
  );

  // Count every one-cycle event pulse, mid-cycle where it has settled
  always @(negedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (lev[i] === 1'b1) ev_l[i]++;
      if (i < 4 && t_ev[i] === 1'b1) ev_t[i]++;
    end
  end

  task automatic chk_b(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic chk_n(input string s, input int e, input int g);
    n_compared++;
    if (g != e) begin
      err_count++;
      $display("MISMATCH %s exp %0d got %0d", s, e, g);
    end
  endtask

  // Write through the host, mirrored in the register model
  task automatic w(input logic [5:0] a, input logic [7:0] d);
    m[a] = d;
    host_u.wr(a, d);
  endtask

  task automatic r(input logic [5:0] a, input logic [7:0] e, input string s);
    logic [7:0] d;
    host_u.rd(a, d);
    chk_b(s, e, d);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Event counters cleared only while no pulse is in flight
  task automatic clr();
    ev_t = '{default: 0};
    ev_l = '{default: 0};
  endtask

  // Timer clocks, two clk high and two low each
  task automatic tc(input int n);
    repeat (n) begin
      @(negedge clk) osc = 1'b1;
      idle(2);
      osc = 1'b0;
      idle(1);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang well past the expected run length
  initial begin
    #(50 * 60000);
    err_count++;
    summarize();
  end

  initial begin
    void'($urandom(47565));
    clr();
    idle(16);
    reset_n = 1'b1;
    // Reset values, then an offset nothing answers
    r(`GPT_OFS_PORT_DATA, 8'h00, "port_data");
    r(`GPT_OFS_EDGE_SELECT, 8'h00, "edge_select");
    r(`GPT_OFS_LINE_DIRECTION, 8'h00, "line_direction");
    r(6'h0b, 8'h00, "unmapped");
    // Random directions, data and pins with interrupts off
    for (int k = 0; k < 6; k++) begin
      pin = 8'($urandom);
      w(`GPT_OFS_LINE_DIRECTION, 8'($urandom));
      w(`GPT_OFS_PORT_DATA, 8'($urandom));
      w(`GPT_OFS_EDGE_SELECT, 8'($urandom));
      idle(2);
      chk_b("line_out", 8'(m[1]), p_out);
      chk_b("line_oe", 8'(m[5]), p_oe);
      r(`GPT_OFS_PORT_DATA, 8'((m[1] & m[5]) | (pin & ~m[5])), "port_rd");
      r(`GPT_OFS_EDGE_SELECT, 8'(m[3]), "edge_rd");
    end
    // Clock enable low: a write must not land, model left untouched
    ce = 1'b0;
    host_u.wr(`GPT_OFS_PORT_DATA, ~p_out);
    idle(2);
    chk_b("ce_hold", 8'(m[1]), p_out);
    ce = 1'b1;
    // Edges chosen before channels are enabled
    w(`GPT_OFS_LINE_DIRECTION, 8'h00);
    pin = 8'h00;
    w(`GPT_OFS_EDGE_SELECT, 8'h01);
    w(`GPT_OFS_IRQ_ENABLE_A, 8'h80);
    w(`GPT_OFS_IRQ_ENABLE_B, 8'h01);
    idle(8);
    clr();
    foreach (seq[i]) begin
      pin = seq[i];
      idle(8);
    end
    // Edge bit flip with the pin low makes its own transition
    w(`GPT_OFS_EDGE_SELECT, 8'h00);
    idle(8);
    chk_n("line0", 2, ev_l[0]);
    chk_n("line7", 1, ev_l[7]);
    chk_n("line1", 0, ev_l[1]);
    // Timer C delay, divide by 4, reload 02
    w(`GPT_OFS_IRQ_ENABLE_A, 8'h21);
    w(`GPT_OFS_IRQ_ENABLE_B, 8'h78);
    w(`GPT_OFS_TMR_DATA_C, 8'h02);
    w(`GPT_OFS_TMR_CTRL_CD, 8'h10);
    clr();
    tc(24);
    idle(8);
    chk_n("c_timeouts", 3, ev_t[2]);
    chk_b("c_out", 8'h01, {7'h00, t_out[2]});
    // Running write waits for the next reload
    w(`GPT_OFS_TMR_DATA_C, 8'h01);
    clr();
    tc(16);
    idle(8);
    chk_n("c_reload", 3, ev_t[2]);
    // Timer D reload 00 spans 256 count pulses
    w(`GPT_OFS_TMR_DATA_D, 8'h00);
    w(`GPT_OFS_TMR_CTRL_CD, 8'h11);
    clr();
    tc(1023);
    idle(8);
    chk_n("d_early", 0, ev_t[3]);
    tc(1);
    idle(8);
    chk_n("d_256", 1, ev_t[3]);
    // Every delay divisor with reload 01
    for (int k = 1; k < 8; k++) begin
      w(`GPT_OFS_TMR_CTRL_CD, 8'h10);
      w(`GPT_OFS_TMR_DATA_D, 8'h01);
      w(`GPT_OFS_TMR_CTRL_CD, 8'(8'h10 | k));
      clr();
      tc(2 * divs[k-1]);
      idle(8);
      chk_n("d_div", 2, ev_t[3]);
    end
    // Timer A pulse width, aux active high
    w(`GPT_OFS_TMR_CTRL_CD, 8'h00);
    w(`GPT_OFS_EDGE_SELECT, 8'h10);
    w(`GPT_OFS_TMR_DATA_A, 8'h02);
    w(`GPT_OFS_TMR_CTRL_A, 8'h09);
    idle(8);
    clr();
    aux_a = 1'b1;
    aux_b = 1'b1;
    pin = 8'h10;
    idle(4);
    tc(24);
    idle(4);
    aux_a = 1'b0;
    aux_b = 1'b0;
    idle(4);
    tc(16);
    idle(8);
    chk_n("a_gated", 3, ev_t[0]);
    chk_b("a_out", 8'h01, {7'h00, t_out[0]});
    chk_n("aux_end", 1, ev_l[4]);
    chk_n("line3", 0, ev_l[3]);
    // Edge bit zero turns aux active low; data rewritten
    w(`GPT_OFS_EDGE_SELECT, 8'h00);
    w(`GPT_OFS_TMR_DATA_A, 8'h02);
    idle(8);
    clr();
    tc(8);
    idle(4);
    aux_a = 1'b1;
    idle(4);
    tc(8);
    idle(8);
    chk_n("a_low", 1, ev_t[0]);
    // Stopped again, line 4 answers its pin once more
    w(`GPT_OFS_TMR_CTRL_A, 8'h00);
    idle(8);
    clr();
    pin = 8'h00;
    idle(8);
    chk_n("line4", 1, ev_l[4]);
    // Timer B event count: edge bit 3 zero counts falling aux edges
    w(`GPT_OFS_TMR_DATA_B, 8'h02);
    w(`GPT_OFS_TMR_CTRL_B, 8'h08);
    idle(8);
    clr();
    repeat (4) begin
      aux_b = 1'b1;
      idle(4);
      aux_b = 1'b0;
      idle(4);
    end
    idle(4);
    chk_n("b_events", 2, ev_t[1]);
    chk_n("b_line3", 4, ev_l[3]);
    summarize();
  end
endmodule
`default_nettype wire
